// File: cpic_defines.svh
/*
 Field positions, exchange word indices, opcodes and masks for the
 instruction-control front end. Included by cpic_stack and cpic_ctrl;
 definitions only.
*/
`ifndef CPIC_DEFINES_SVH
`define CPIC_DEFINES_SVH

// exchange package word indices of the seven support registers
`define CPIC_XW_COUNTER 3'h0
`define CPIC_XW_BASE 3'h1
`define CPIC_XW_LIMIT 3'h2
`define CPIC_XW_EXIT 3'h3
`define CPIC_XW_EXT_BASE 3'h4
`define CPIC_XW_EXT_LIMIT 3'h5
`define CPIC_XW_MONITOR 3'h6
`define CPIC_XW_LAST 3'h6

// exit-mode bits sit in two 3-bit groups of the fourth word
`define CPIC_EM_LO_POS 48
`define CPIC_EM_HI_POS 57

// opcodes (two octal digits in six bits) and the 01x sub-codes
`define CPIC_OP_JUMP 6'h02
`define CPIC_OP_GROUP01 6'h01
`define CPIC_SUB_RETURN 3'h0
`define CPIC_SUB_EXT_TO_CM 3'h1
`define CPIC_SUB_CM_TO_EXT 3'h2

`define CPIC_PARCELS 3'h4
`define CPIC_PREFETCH_AHEAD 18'h2

// maintenance switch masks over address-stack ranks 1..12
`define CPIC_DIS_LONG_MASK 12'h3FF
`define CPIC_DIS_SHORT_MASK 12'h00F

`define CPIC_RST_VAL '0

`endif

// File: cpic_pkg.sv
/*
 Types of the instruction-control front end: sequencer states and the
 packed state record of the main module. Assumes cpic_defines.svh.
*/
package cpic_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_XRD,
      ST_XWR,
      ST_RUN
   } cpic_state_t;

   typedef struct packed {
      cpic_state_t st;
      logic running;
      logic [17:0] p;
      logic [17:0] base;
      logic [17:0] limit;
      logic [5:0] em;
      logic [20:0] extBase;
      logic [23:0] extLimit;
      logic [17:0] monAddr;
      logic [59:0] current_instruction_word;
      logic [2:0] parcels;
      logic [2:0] xIdx;
      logic [17:0] pkgAddr;
      logic [59:0] xWord;
      logic [17:0] fetchAddr;
      logic drop;
      logic memReq;
      logic memWe;
      logic [17:0] memAddr;
      logic [59:0] memWdata;
      logic [7:1][17:0] bReg;
      logic issueValid;
      logic issueLong;
      logic [29:0] issueInstr;
      logic copyValid;
      logic copyToCm;
      logic copyExtErr;
      logic [17:0] copyCount;
      logic [17:0] copyCmAddr;
      logic [23:0] copyExtAddr;
      logic retLinkValid;
      logic [17:0] retLink;
      logic [17:0] absAddr;
      logic rangeErr;
      logic errorExit;
      logic [1:0] syn1;
      logic [1:0] syn2;
      logic [1:0] syn3;
      logic [1:0] dis;
   } cpic_ctl_t;

endpackage : cpic_pkg

// File: cpic_stack.sv
/*
 Instruction word stack with its address stack: newest word enters the top
 rank, every rank compares its address with the program address.
 Assumes one clock, synchronous reset and a freezing clock enable.
*/
`timescale 1ns/1ps
`include "cpic_defines.svh"
module cpic_stack
   import cpic_pkg::*;
#(
   parameter int DEPTH = 12,
   parameter int W = 60,
   parameter int AW = 18
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic push,
   input wire logic [W-1:0] pushWord,
   input wire logic [AW-1:0] pushAddr,
   input wire logic clear,
   input wire logic [DEPTH-1:0] disMask,
   input wire logic [AW-1:0] lookAddr,
   output logic hit,
   output logic [W-1:0] hitWord
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] word;
      logic [DEPTH-1:0][AW-1:0] addr;
      logic [DEPTH-1:0] vld;
   } cpic_stk_t;

   cpic_stk_t s_r;
   cpic_stk_t s_nxt;
   logic [DEPTH-1:0] match;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      if (clear) begin
         s_nxt.vld = '0; // [RL13]
      end else if (push) begin
         // index DEPTH-1 is the top rank; index 0 loses its word
         s_nxt.word = {pushWord, s_r.word[DEPTH-1:1]}; // [RL14]
         s_nxt.addr = {pushAddr, s_r.addr[DEPTH-1:1]}; // [RL15]
         s_nxt.vld = {1'b1, s_r.vld[DEPTH-1:1]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= `CPIC_RST_VAL;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   for (genvar r = 0; r < DEPTH; r++) begin : g_rank
      assign match[r] = s_r.vld[r] && !disMask[r] &&
                        (s_r.addr[r] == lookAddr); // [RL15] [RL16]
   end

   // after a backward jump two ranks may hold one address; newest wins
   always_comb begin
      hitWord = '0;
      for (int r = 0; r < DEPTH; r++) begin
         if (match[r]) begin
            hitWord = s_r.word[r];
         end
      end
   end

   assign hit = |match;

   ////////////////////////////////////////////////////////////////////////
   chk_rank_shift: assert property (@(posedge clk) disable iff (rst)
      ce && push && !clear |=> s_r.word[DEPTH-1] == $past(pushWord) &&
      s_r.word[0] == $past(s_r.word[1])) // [RL14]
      else $error("stack did not shift on push");

   chk_void_clear: assert property (@(posedge clk) disable iff (rst)
      ce && clear |=> !hit) // [RL13]
      else $error("voided stack still hits");

   cov_stack_full: cover property (@(posedge clk) disable iff (rst)
      s_r.vld[0]);

endmodule : cpic_stack

// File: cpic_ctrl.sv
/*
 Instruction-control front end: index bank, support registers loaded and
 stored by the exchange sequence, instruction stack prefetch, current
 instruction word, counter update, jumps and block-copy addressing.
 Assumes the memory controller answers each request with one memAck cycle
 and drives exchange starts; the maintenance switches are asynchronous.
*/
`timescale 1ns/1ps
`include "cpic_defines.svh"
// How it works
// [RL1] index zero always reads zero; writes aimed at it are dropped
// [RL2] exchange loads support registers, holds them, writes old values back
// [RL3] counter comes from exchange word one, holds current relative address
// [RL4] processor addresses get memory base added; peripheral references bypass
// [RL5] relative addresses compare with memory limit to flag out-of-field
// [RL6] set exit-mode bit turns its condition into an error exit
// [RL7] exit-mode bits at package bits 48-50 and 57-59, fixed order
// [RL8] extended base from word five, added to extended relative address
// [RL9] extended limit from word six, compared with extended relative address
// [RL10] monitor address from word seven supplies package start, flag clear
// [RL11] twelve-word stack prefetches two words ahead of executing address
// [RL12] loops of up to ten words rerun from stack without fetches
// [RL13] jump out of stack voids it and restarts fetching
// [RL14] arriving word enters top rank, ranks shift down, bottom dropped
// [RL15] each rank's address compares with counter; match feeds instruction word
// [RL16] maintenance switches disable address ranks 1-10 or 1-4
// [RL17] four parcels load together, issue without conflict, shift 15/30
// [RL18] counter increments on every load of the instruction word
// [RL19] branch loads counter; return jump saves counter plus one first
// [RL20] exchange starts only when memory controller commands it
// [RL21] block copy of Bj+K words at A0+base and X0+extended base
// [RL22] op 02 jumps to Bi+K, voids stack; K alone when i zero
module cpic_ctrl
   import cpic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic xchgStart,
   input wire logic [17:0] xchgAddr,
   input wire logic xchgToMonitor,
   input wire logic monitorFlag,
   output logic memReq,
   output logic memWe,
   output logic [17:0] memAddr,
   output logic [59:0] memWdata,
   input wire logic memAck,
   input wire logic [59:0] memRdata,
   input wire logic issueOk,
   output logic issueValid,
   output logic issueLong,
   output logic [29:0] issueInstr,
   input wire logic brTake,
   input wire logic [17:0] brTarget,
   input wire logic bWe,
   input wire logic [2:0] bWaddr,
   input wire logic [17:0] bWdata,
   input wire logic [17:0] regA0,
   input wire logic [59:0] regX0,
   output logic copyValid,
   output logic copyToCm,
   output logic [17:0] copyCount,
   output logic [17:0] copyCmAddr,
   output logic [23:0] copyExtAddr,
   output logic copyExtErr,
   output logic retLinkValid,
   output logic [17:0] retLink,
   input wire logic relValid,
   input wire logic relFromPp,
   input wire logic [17:0] relAddr,
   output logic [17:0] absAddr,
   output logic rangeErr,
   input wire logic [5:0] errCond,
   output logic errorExit,
   output logic running,
   output logic [17:0] instructionCounter,
   output logic [17:0] monitorAddress,
   input wire logic maintDisLong,
   input wire logic maintDisShort
);

   cpic_ctl_t s_r;
   cpic_ctl_t s_nxt;
   logic stkHit;
   logic [59:0] stkWord;
   logic stkPush;
   logic stkClear;
   logic [11:0] disMask;
   logic doVoid;
   logic ciwLoad;
   logic doJump;
   logic doRet;

   wire [5:0] opField = s_r.current_instruction_word[59:54];
   wire [2:0] iField = s_r.current_instruction_word[53:51];
   wire [2:0] jField = s_r.current_instruction_word[50:48];
   wire [17:0] kField = s_r.current_instruction_word[47:30];

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [17:0] bRead(input cpic_ctl_t s,
                                          input logic [2:0] idx);
      if (idx == 3'h0) begin
         return 18'h00000; // [RL1]
      end
      return s.bReg[idx];
   endfunction : bRead

   function automatic logic isLong(input logic [5:0] op);
      logic lowGroup;
      logic incGroup;
      lowGroup = (op[5:3] == 3'h0) && (op != 6'h00);
      incGroup = (op[5:3] >= 3'h5) && (op[2:0] <= 3'h2);
      return lowGroup || incGroup;
   endfunction : isLong

   // value written back for package word idx
   function automatic logic [59:0] oldWord(input cpic_ctl_t s,
                                           input logic [2:0] idx);
      logic [59:0] w;
      w = '0;
      case (idx)
         `CPIC_XW_COUNTER: w[17:0] = s.p;
         `CPIC_XW_BASE: w[17:0] = s.base;
         `CPIC_XW_LIMIT: w[17:0] = s.limit;
         `CPIC_XW_EXIT: begin
            w[`CPIC_EM_LO_POS+2:`CPIC_EM_LO_POS] = s.em[2:0]; // [RL7]
            w[`CPIC_EM_HI_POS+2:`CPIC_EM_HI_POS] = s.em[5:3];
         end
         `CPIC_XW_EXT_BASE: w[20:0] = s.extBase;
         `CPIC_XW_EXT_LIMIT: w[23:0] = s.extLimit;
         `CPIC_XW_MONITOR: w[17:0] = s.monAddr;
         default: w = '0;
      endcase
      return w;
   endfunction : oldWord

   ////////////////////////////////////////////////////////////////////////
   assign disMask = (s_r.dis[1] ? `CPIC_DIS_LONG_MASK : 12'h000) |
                    (s_r.dis[0] ? `CPIC_DIS_SHORT_MASK : 12'h000); // [RL16]

   cpic_stack #(
      .DEPTH(12),
      .W(60),
      .AW(18)
   ) u_stack (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .push(stkPush),
      .pushWord(memRdata),
      .pushAddr(s_r.fetchAddr),
      .clear(stkClear),
      .disMask(disMask),
      .lookAddr(s_r.p),
      .hit(stkHit),
      .hitWord(stkWord)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [24:0] extEnd;
      logic [17:0] cnt;
      logic [2:0] nextIdx;
      extEnd = '0;
      cnt = '0;
      nextIdx = 3'(s_r.xIdx + 3'h1);
      s_nxt = s_r;
      s_nxt.issueValid = 1'b0;
      s_nxt.copyValid = 1'b0;
      s_nxt.retLinkValid = 1'b0;
      stkPush = 1'b0;
      stkClear = 1'b0;
      doVoid = 1'b0;
      ciwLoad = 1'b0;
      doJump = 1'b0;
      doRet = 1'b0;

      // switch pins: three stages, accepted when stages two and three agree
      s_nxt.syn1 = {maintDisLong, maintDisShort};
      s_nxt.syn2 = s_r.syn1;
      s_nxt.syn3 = s_r.syn2;
      if (s_r.syn2 == s_r.syn3) begin
         s_nxt.dis = s_r.syn3;
      end

      if (bWe && bWaddr != 3'h0) begin
         s_nxt.bReg[bWaddr] = bWdata; // [RL1]
      end

      if (relValid) begin
         s_nxt.absAddr = relFromPp ? relAddr :
                         18'(relAddr + s_r.base); // [RL4]
         s_nxt.rangeErr = !relFromPp && (relAddr >= s_r.limit); // [RL5]
      end
      // bit 0 (address range) also fed by our own range checks
      s_nxt.errorExit = s_r.running &&
         |(s_r.em & (errCond |
                     {5'h00, s_r.rangeErr | s_r.copyExtErr})); // [RL6]

      case (s_r.st)
         ST_IDLE: begin
         end
         ST_XRD: begin
            if (memAck) begin
               s_nxt.xWord = memRdata;
               s_nxt.memWe = 1'b1;
               s_nxt.memWdata = oldWord(s_r, s_r.xIdx); // [RL2]
               s_nxt.st = ST_XWR;
            end
         end
         ST_XWR: begin
            if (memAck) begin
               case (s_r.xIdx) // [RL2]
                  `CPIC_XW_COUNTER: s_nxt.p = s_r.xWord[17:0]; // [RL3]
                  `CPIC_XW_BASE: s_nxt.base = s_r.xWord[17:0]; // [RL4]
                  `CPIC_XW_LIMIT: s_nxt.limit = s_r.xWord[17:0]; // [RL5]
                  `CPIC_XW_EXIT: s_nxt.em = {
                     s_r.xWord[`CPIC_EM_HI_POS+2:`CPIC_EM_HI_POS],
                     s_r.xWord[`CPIC_EM_LO_POS+2:`CPIC_EM_LO_POS]}; // [RL7]
                  `CPIC_XW_EXT_BASE: s_nxt.extBase = s_r.xWord[20:0]; // [RL8]
                  `CPIC_XW_EXT_LIMIT: s_nxt.extLimit = s_r.xWord[23:0];//[RL9]
                  `CPIC_XW_MONITOR: s_nxt.monAddr = s_r.xWord[17:0]; // [RL10]
                  default: s_nxt.monAddr = s_r.monAddr;
               endcase
               s_nxt.memWe = 1'b0;
               if (s_r.xIdx == `CPIC_XW_LAST) begin
                  s_nxt.memReq = 1'b0;
                  s_nxt.st = ST_RUN;
                  s_nxt.running = 1'b1;
                  stkClear = 1'b1;
                  s_nxt.fetchAddr = s_r.p;
               end else begin
                  s_nxt.xIdx = nextIdx;
                  s_nxt.memAddr = 18'(s_r.pkgAddr + 18'(nextIdx));
                  s_nxt.st = ST_XRD;
               end
            end
         end
         ST_RUN: begin
            if (s_r.memReq && memAck) begin
               s_nxt.memReq = 1'b0;
               s_nxt.drop = 1'b0;
               if (!s_r.drop) begin
                  stkPush = 1'b1; // [RL14]
                  s_nxt.fetchAddr = 18'(s_r.fetchAddr + 18'h1);
               end
            end
            if (s_r.parcels == 3'h0) begin
               if (stkHit) begin // [RL12]
                  ciwLoad = 1'b1;
                  s_nxt.current_instruction_word = stkWord; // [RL15] [RL17]
                  s_nxt.parcels = `CPIC_PARCELS;
                  s_nxt.p = 18'(s_r.p + 18'h1); // [RL18]
               end else if (s_r.fetchAddr != s_r.p) begin
                  doVoid = 1'b1; // [RL13]
               end
            end else if (issueOk) begin
               if (opField == `CPIC_OP_JUMP) begin
                  doJump = 1'b1;
                  s_nxt.p = 18'(bRead(s_r, iField) + kField); // [RL22]
                  s_nxt.parcels = 3'h0;
                  doVoid = 1'b1; // [RL22]
               end else if (opField == `CPIC_OP_GROUP01 &&
                            iField == `CPIC_SUB_RETURN) begin
                  doRet = 1'b1;
                  // counter already runs one past the word in progress
                  s_nxt.retLinkValid = 1'b1;
                  s_nxt.retLink = s_r.p; // [RL19]
                  s_nxt.p = kField; // [RL19]
                  s_nxt.parcels = 3'h0;
               end else begin
                  if (opField == `CPIC_OP_GROUP01) begin
                     cnt = 18'(bRead(s_r, jField) + kField); // [RL21]
                     extEnd = 25'(regX0[23:0]) + 25'(cnt);
                     s_nxt.copyValid = 1'b1;
                     s_nxt.copyToCm = (iField == `CPIC_SUB_EXT_TO_CM);
                     s_nxt.copyCount = cnt;
                     s_nxt.copyCmAddr = 18'(regA0 + s_r.base); // [RL21]
                     s_nxt.copyExtAddr = 24'(regX0[23:0] +
                                             24'(s_r.extBase)); // [RL8]
                     s_nxt.copyExtErr = extEnd >
                                        25'(s_r.extLimit); // [RL9]
                  end else begin
                     s_nxt.issueValid = 1'b1; // [RL17]
                     s_nxt.issueInstr = s_r.current_instruction_word[59:30];
                     s_nxt.issueLong = isLong(opField);
                  end
                  if (isLong(opField)) begin
                     s_nxt.current_instruction_word = {s_r.current_instruction_word[29:0], 30'h0}; // [RL17]
                     s_nxt.parcels = (s_r.parcels > 3'h2) ?
                                     3'(s_r.parcels - 3'h2) : 3'h0;
                  end else begin
                     s_nxt.current_instruction_word = {s_r.current_instruction_word[44:0], 15'h0000};
                     s_nxt.parcels = 3'(s_r.parcels - 3'h1);
                  end
               end
            end
            if (brTake) begin
               s_nxt.p = brTarget; // [RL19]
               s_nxt.parcels = 3'h0;
            end
            if (doVoid) begin
               stkClear = 1'b1; // [RL13]
               s_nxt.fetchAddr = s_nxt.p;
               s_nxt.drop = s_nxt.memReq;
            end
            // prefetch only while short of two words ahead
            if (!s_nxt.memReq && s_nxt.fetchAddr <=
                18'(s_nxt.p - 18'h1 + `CPIC_PREFETCH_AHEAD)) begin // [RL11]
               s_nxt.memReq = 1'b1;
               s_nxt.memWe = 1'b0;
               s_nxt.memAddr = 18'(s_r.base + s_nxt.fetchAddr); // [RL4]
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // a pending fetch is abandoned; the controller owns that choice
      if (xchgStart) begin // [RL20]
         s_nxt.st = ST_XRD;
         s_nxt.running = 1'b0;
         s_nxt.xIdx = `CPIC_XW_COUNTER;
         s_nxt.pkgAddr = (xchgToMonitor && !monitorFlag) ?
                         s_r.monAddr : xchgAddr; // [RL10]
         s_nxt.memAddr = s_nxt.pkgAddr;
         s_nxt.memReq = 1'b1;
         s_nxt.memWe = 1'b0;
         s_nxt.parcels = 3'h0;
         s_nxt.drop = 1'b0;
         stkPush = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= `CPIC_RST_VAL;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign memReq = s_r.memReq;
   assign memWe = s_r.memWe;
   assign memAddr = s_r.memAddr;
   assign memWdata = s_r.memWdata;
   assign issueValid = s_r.issueValid;
   assign issueLong = s_r.issueLong;
   assign issueInstr = s_r.issueInstr;
   assign copyValid = s_r.copyValid;
   assign copyToCm = s_r.copyToCm;
   assign copyCount = s_r.copyCount;
   assign copyCmAddr = s_r.copyCmAddr;
   assign copyExtAddr = s_r.copyExtAddr;
   assign copyExtErr = s_r.copyExtErr;
   assign retLinkValid = s_r.retLinkValid;
   assign retLink = s_r.retLink;
   assign absAddr = s_r.absAddr;
   assign rangeErr = s_r.rangeErr;
   assign errorExit = s_r.errorExit;
   assign running = s_r.running;
   assign instructionCounter = s_r.p;
   assign monitorAddress = s_r.monAddr;

   ////////////////////////////////////////////////////////////////////////
   wire [17:0] biValue = bRead(s_r, iField);
   chk_jump_target: assert property (@(posedge clk) disable iff (rst)
      ce && doJump && !brTake && !xchgStart |=>
      s_r.p == 18'($past(biValue) + $past(kField))) // [RL22]
      else $error("jump target wrong");

   chk_jump_zero: assert property (@(posedge clk) disable iff (rst)
      ce && doJump && iField == 3'h0 && !brTake && !xchgStart |=>
      s_r.p == $past(kField) && s_r.parcels == 3'h0) // [RL1]
      else $error("zero index jump not to K");

   chk_counter_step: assert property (@(posedge clk) disable iff (rst)
      ce && ciwLoad && !brTake && !xchgStart |=>
      s_r.p == 18'($past(s_r.p) + 18'h1) && s_r.parcels == 3'h4) // [RL18]
      else $error("counter not advanced on word load");

   chk_support_hold: assert property (@(posedge clk) disable iff (rst)
      ce && s_r.running && !xchgStart |=> $stable(s_r.base) &&
      $stable(s_r.limit) && $stable(s_r.em) && $stable(s_r.extLimit))//[RL2]
      else $error("support register moved while running");

   chk_xchg_cause: assert property (@(posedge clk) disable iff (rst)
      ce && !xchgStart && (s_r.st == ST_RUN || s_r.st == ST_IDLE) |=>
      (s_r.st == ST_RUN || s_r.st == ST_IDLE)) // [RL20]
      else $error("exchange began without controller command");

   chk_abs_addr: assert property (@(posedge clk) disable iff (rst)
      ce && relValid && !relFromPp |=>
      absAddr == 18'($past(relAddr) + $past(s_r.base))) // [RL4]
      else $error("absolute address not base plus relative");

   chk_range_flag: assert property (@(posedge clk) disable iff (rst)
      ce && relValid && !relFromPp |=>
      rangeErr == ($past(relAddr) >= $past(s_r.limit))) // [RL5]
      else $error("limit compare wrong");

   chk_exit_mode: assert property (@(posedge clk) disable iff (rst)
      ce && s_r.running && |(s_r.em & errCond) |=> errorExit) // [RL6]
      else $error("selected condition gave no error exit");

   chk_return_link: assert property (@(posedge clk) disable iff (rst)
      ce && doRet && !brTake && !xchgStart |=> retLinkValid &&
      retLink == $past(s_r.p) && s_r.p == $past(kField)) // [RL19]
      else $error("return jump link or target wrong");

   chk_loop_nofetch: assert property (@(posedge clk) disable iff (rst)
      ce && s_r.st == ST_RUN && !s_r.memReq && !doVoid && !brTake &&
      !xchgStart && !doRet && s_r.fetchAddr > 18'(s_r.p + 18'h3) |=>
      !memReq) // [RL12]
      else $error("fetch issued while stack is ahead");

   cov_xchg_done: cover property (@(posedge clk) disable iff (rst)
      s_r.st == ST_XWR ##1 s_r.st == ST_RUN);
   cov_jump: cover property (@(posedge clk) disable iff (rst) doJump);
   cov_copy: cover property (@(posedge clk) disable iff (rst) copyValid);
   cov_loop_hit: cover property (@(posedge clk) disable iff (rst)
      ciwLoad && !s_r.memReq && s_r.fetchAddr > 18'(s_r.p + 18'h2));

endmodule : cpic_ctrl

// File: cpic_mem.sv
/*
 Memory controller and central memory stand-in for cpic_ctrl.
 Assumes each request holds until the edge that samples memAck.
*/
`timescale 1ns/1ps
module cpic_mem (
   input wire logic clk,
   input wire logic slow,
   input wire logic abort,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [17:0] memAddr,
   input wire logic [59:0] memWdata,
   output logic memAck,
   output logic [59:0] memRdata
);
   logic [59:0] mem [0:1023];
   logic [1:0] wait_r = 2'h0;
   initial memAck = 1'b0;
   initial memRdata = 60'h0;
   // read data toggles when idle so a stale word never looks valid
   always @(posedge clk) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else if (memReq && !memAck && !abort) begin
         memAck <= 1'b1;
         wait_r <= {slow, slow};
         if (memWe) mem[memAddr[9:0]] <= memWdata;
         else memRdata <= mem[memAddr[9:0]];
      end
   end
endmodule : cpic_mem

// File: tb.sv
/*
 Self-checking bench for cpic_ctrl against the memory stand-in.
 Assumes a 20 MHz clock and low-bit exchange word fields.
*/
`timescale 1ns/1ps
module tb;
   localparam logic [14:0] PA = 15'h1053;
   localparam logic [14:0] PB = 15'h1A5C;
   localparam logic [17:0] CK = 18'h00010;
   localparam logic [5:0] EM = 6'h2E;
   localparam logic [59:0] PKG [0:6] = '{60'h20, 60'h200, 60'h40,
      60'hA06000000000000, 60'h12345, 60'hABCDEF, 60'h3C0};
   logic clk, memReq, memWe, memAck, issueValid, issueLong, copyValid;
   logic copyToCm, copyExtErr, retLinkValid, rangeErr, errorExit, running;
   logic rst = 1'b1, ce = 1'b1, xchgStart = 1'b0, xchgToMonitor = 1'b0;
   logic monitorFlag = 1'b0, issueOk = 1'b0, brTake = 1'b0, bWe = 1'b0;
   logic relValid = 1'b0, relFromPp = 1'b0, slow = 1'b0;
   logic maintDisLong = 1'b0, maintDisShort = 1'b0;
   logic [2:0] bWaddr = 3'h0;
   logic [5:0] errCond = 6'h0;
   logic [17:0] xchgAddr = 18'h0, brTarget = 18'h0, bWdata = 18'h0;
   logic [17:0] regA0 = 18'h0, relAddr = 18'h0, a0Seen;
   logic [17:0] memAddr, copyCount, copyCmAddr, retLink, absAddr;
   logic [17:0] instructionCounter, monitorAddress;
   logic [23:0] copyExtAddr, x0Seen;
   logic [29:0] issueInstr;
   logic [59:0] memWdata, memRdata, regX0 = 60'h0;
   logic [31:0] seed = 32'h0001481E, r;
   logic [14:0] prev, exp;
   int error_cnt = 0, checked = 0, t;
   cpic_ctrl dut (.clk, .rst, .ce, .xchgStart, .xchgAddr, .xchgToMonitor,
      .monitorFlag, .memReq, .memWe, .memAddr, .memWdata, .memAck,
      .memRdata, .issueOk, .issueValid, .issueLong, .issueInstr, .brTake,
      .brTarget, .bWe, .bWaddr, .bWdata, .regA0, .regX0, .copyValid,
      .copyToCm, .copyCount, .copyCmAddr, .copyExtAddr, .copyExtErr,
      .retLinkValid, .retLink, .relValid, .relFromPp, .relAddr, .absAddr,
      .rangeErr, .errCond, .errorExit, .running, .instructionCounter,
      .monitorAddress, .maintDisLong, .maintDisShort);
   cpic_mem m (.clk, .slow, .abort(xchgStart), .memReq, .memWe, .memAddr,
      .memWdata, .memAck, .memRdata);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [59:0] seen, input logic [59:0] want);
      checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check
   task automatic final_report();
      $display("checks=%0d errors=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic xchg(input logic [17:0] a);
      @(posedge clk);
      xchgAddr <= a;
      xchgStart <= 1'b1;
      @(posedge clk);
      xchgStart <= 1'b0;
      @(posedge clk);
      t = 0;
      do @(negedge clk); while (running !== 1'b1 && ++t < 400);
      check(running, 1'b1);
   endtask : xchg
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // stalls from issueOk and a slow memory are mixed in at random
   always @(posedge clk) begin
      issueOk <= seed[0] | seed[1];
      slow <= seed[2];
      monitorFlag <= seed[3];
      regA0 <= seed[21:4];
      regX0 <= {28'h0, rnd()};
      brTarget <= seed[17:0];
      {a0Seen, x0Seen} <= {regA0, regX0[23:0]};
   end
   always @(negedge clk) begin
      if (copyValid === 1'b1) begin
         check({copyToCm, copyCount}, {1'b1, CK});
         check(copyCmAddr, 18'(a0Seen + 18'h200));
         check(copyExtAddr, 24'(x0Seen + 24'h12345));
         check(copyExtErr, 25'(x0Seen) + CK > 25'hABCDEF);
      end
      if (retLinkValid === 1'b1) check(retLink, 18'h22);
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end
   initial begin
      for (int k = 0; k < 1024; k++) m.mem[k] = 60'h0;
      for (int k = 0; k < 7; k++) m.mem[10'h100 + k] = PKG[k];
      m.mem[10'h220] = {PA, PB, 6'h01, 3'h1, 3'h0, CK};
      m.mem[10'h221] = {6'h01, 6'h00, 18'h00022, 30'h0};
      m.mem[10'h222] = {6'h02, 6'h00, 18'h00020, 30'h0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      bWe <= 1'b1;
      bWdata <= 18'h3FFFF;
      @(posedge clk);
      bWe <= 1'b0;
      @(negedge clk);
      check(memReq, 1'b0);
      xchg(18'h100);
      check(instructionCounter, 18'h20);
      check(monitorAddress, 18'h3C0);
      check(m.mem[10'h101], 60'h0);
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         r = rnd();
         relValid <= 1'b1;
         relFromPp <= r[31];
         relAddr <= {11'h0, r[6:0]};
         errCond <= r[29:24];
         @(posedge clk);
         relValid <= 1'b0;
         @(negedge clk);
         check(absAddr, {11'h0, r[6:0]} + (r[31] ? 18'h0 : 18'h200));
         check(rangeErr, !r[31] && r[6:0] >= 7'h40);
         check(errorExit, |(EM & r[29:24]));
      end
      @(posedge clk);
      errCond <= 6'h0;
      prev = PB;
      for (int n = 0; n < 8; n++) begin
         t = 0;
         do @(negedge clk); while (issueValid !== 1'b1 && ++t < 300);
         check(issueValid, 1'b1);
         check(issueLong, 1'b0);
         exp = (prev === PA) ? PB : PA;
         if (n == 0 && issueInstr[29:15] === PB) exp = PB;
         check(issueInstr[29:15], exp);
         if (exp === PA) check(instructionCounter, 18'h21);
         prev = issueInstr[29:15];
      end
      xchg(18'h140);
      for (int k = 1; k < 7; k++) check(m.mem[10'h140 + k], PKG[k]);
      final_report();
   end
endmodule : tb
